// ==== pkg/eas_params.svh ====
`ifndef EAS_PARAMS_SVH
`define EAS_PARAMS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define EAS_PAIRS 20
`define EAS_IDX_W 5
`define EAS_ACT_W 6
`define EAS_SRC_W 5
`define EAS_NUM_CMP 4
`define EAS_NUM_LR 4
`define EAS_NUM_STAT 8
`define EAS_NUM_TMR 4
`define EAS_NUM_DIN 8
`define EAS_VAL_W 16

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define EAS_CTRL_OFF 12'h000
`define EAS_STAT_OFF 12'h004
`define EAS_CMP_BASE 12'h010
`define EAS_LR_BASE 12'h020
`define EAS_PAIR_BASE 12'h040

// ----------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------
`define EAS_CTRL_EN_BIT 0
`define EAS_CTRL_CNT_LSB 8
`define EAS_CNT_RST 5'h01
`define EAS_CNT_MAX 5'h14

// ----------------------------------------------------------------
// pair, comparator and logic rule fields
// ----------------------------------------------------------------
`define EAS_PAIR_EV_LSB 0
`define EAS_PAIR_ACT_LSB 8
`define EAS_CMP_PRE_LSB 0
`define EAS_CMP_SRC_LSB 16
`define EAS_CMP_OP_LSB 18
`define EAS_LR_A_LSB 0
`define EAS_LR_B_LSB 5
`define EAS_LR_C_LSB 10
`define EAS_LR_OPAB_LSB 15
`define EAS_LR_OPBC_LSB 17
`define EAS_LR_INV_LSB 19

// ----------------------------------------------------------------
// boolean source bus layout
// ----------------------------------------------------------------
`define EAS_SRC_FALSE 0
`define EAS_SRC_TRUE 1
`define EAS_SRC_STAT 2
`define EAS_SRC_CMP 10
`define EAS_SRC_LR 14
`define EAS_SRC_TMR 18
`define EAS_SRC_DIN 22
`define EAS_SRC_EVT 30
`define EAS_SRC_RUN 31

`endif

// ==== pkg/eas_pkg.sv ====
package eas_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    EAS_IDLE = 2'b01,
    EAS_RUN = 2'b10
  } eas_state_t;

  // comparator operators
  typedef enum logic [1:0] {
    EAS_CMP_LT = 2'h0,
    EAS_CMP_EQ = 2'h1,
    EAS_CMP_GT = 2'h2,
    EAS_CMP_NE = 2'h3
  } eas_cmp_op_t;

  // logic rule joining operators
  typedef enum logic [1:0] {
    EAS_LOP_PASS = 2'h0,
    EAS_LOP_AND = 2'h1,
    EAS_LOP_OR = 2'h2,
    EAS_LOP_XOR = 2'h3
  } eas_lop_t;
endpackage

// ==== hw/eas_logic_rule.sv ====
`timescale 1ns/10ps
`include "eas_params.svh"
module eas_logic_rule
  import eas_pkg::*;
(
  // boolean sources
  input wire logic [31:0] srcBus,
  // configuration
  input wire logic [`EAS_SRC_W-1:0] selA,
  input wire logic [`EAS_SRC_W-1:0] selB,
  input wire logic [`EAS_SRC_W-1:0] selC,
  input wire logic [1:0] opAb,
  input wire logic [1:0] opBc,
  input wire logic [2:0] invert,
  // result
  output logic result
);
  logic a;
  logic b;
  logic c;
  logic ab;

  // pick and optionally invert the three inputs
  assign a = srcBus[selA] ^ invert[0];
  assign b = srcBus[selB] ^ invert[1];
  assign c = srcBus[selC] ^ invert[2];

  // join left to right: (a op b) op c
  always_comb begin
    case (eas_lop_t'(opAb))
      EAS_LOP_AND: ab = a & b;
      EAS_LOP_OR: ab = a | b;
      EAS_LOP_XOR: ab = a ^ b;
      default: ab = a;
    endcase
    case (eas_lop_t'(opBc))
      EAS_LOP_AND: result = ab & c;
      EAS_LOP_OR: result = ab | c;
      EAS_LOP_XOR: result = ab ^ c;
      default: result = ab;
    endcase
  end
endmodule

// ==== hw/event_action_sequencer.sv ====
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "eas_params.svh"
module event_action_sequencer
  import eas_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // scan pacing
  input wire logic scanStrobe,
  // condition sources
  input wire logic [`EAS_NUM_STAT-1:0] statusBits,
  input wire logic [`EAS_NUM_TMR-1:0] timerBits,
  input wire logic [`EAS_NUM_DIN-1:0] digitalPins,
  input wire logic [`EAS_NUM_CMP*`EAS_VAL_W-1:0] measValues,
  // action sink
  output logic actionFire,
  output logic [`EAS_ACT_W-1:0] actionCode,
  output logic [`EAS_IDX_W-1:0] actionIndex,
  output logic [`EAS_IDX_W-1:0] currentIndex
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  eas_state_t state_q;
  logic enable_q;
  logic [`EAS_IDX_W-1:0] count_q;
  logic [`EAS_IDX_W-1:0] lastIdx;
  logic [`EAS_IDX_W-1:0] idx_q;
  logic [`EAS_IDX_W-1:0] idx_d;
  logic [13:0] pairCfg_q [`EAS_PAIRS];
  logic [19:0] cmpCfg_q [`EAS_NUM_CMP];
  logic [21:0] lrCfg_q [`EAS_NUM_LR];
  logic [`EAS_NUM_DIN-1:0] dinMeta_q;
  logic [`EAS_NUM_DIN-1:0] dinSync_q;
  logic [`EAS_NUM_CMP-1:0] cmpOut;
  logic [`EAS_NUM_LR-1:0] lrOut;
  logic [`EAS_NUM_LR-1:0] lrOut_q;
  logic [31:0] srcBus;
  logic [`EAS_SRC_W-1:0] curSel;
  logic eventTrue;
  logic evtLast_q;
  logic wrPend_q;
  logic rdPend_q;
  logic [11:0] addr_q;
  logic addrPhase;
  logic [31:0] rdMux;
  logic [11:0] wOff;
  logic [`EAS_IDX_W-1:0] wPair;

  // ----------------------------------------------------------------
  // digital input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dinMeta_q <= '0;
      dinSync_q <= '0;
    end else begin
      dinMeta_q <= digitalPins;
      dinSync_q <= dinMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // comparators and logic rules
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `EAS_NUM_CMP; g = g + 1) begin : gCmp
      logic [`EAS_VAL_W-1:0] val;
      logic [`EAS_VAL_W-1:0] pre;
      // one continuous quantity against its preset
      assign val = measValues[cmpCfg_q[g][`EAS_CMP_SRC_LSB +: 2]*`EAS_VAL_W +: `EAS_VAL_W];
      assign pre = cmpCfg_q[g][`EAS_CMP_PRE_LSB +: `EAS_VAL_W];
      always_comb begin
        case (eas_cmp_op_t'(cmpCfg_q[g][`EAS_CMP_OP_LSB +: 2]))
          EAS_CMP_LT: cmpOut[g] = val < pre;
          EAS_CMP_EQ: cmpOut[g] = val == pre;
          EAS_CMP_GT: cmpOut[g] = val > pre;
          default: cmpOut[g] = val != pre;
        endcase
      end
    end
    for (g = 0; g < `EAS_NUM_LR; g = g + 1) begin : gLr
      eas_logic_rule uRule (
        .srcBus(srcBus),
        .selA(lrCfg_q[g][`EAS_LR_A_LSB +: `EAS_SRC_W]),
        .selB(lrCfg_q[g][`EAS_LR_B_LSB +: `EAS_SRC_W]),
        .selC(lrCfg_q[g][`EAS_LR_C_LSB +: `EAS_SRC_W]),
        .opAb(lrCfg_q[g][`EAS_LR_OPAB_LSB +: 2]),
        .opBc(lrCfg_q[g][`EAS_LR_OPBC_LSB +: 2]),
        .invert(lrCfg_q[g][`EAS_LR_INV_LSB +: 3]),
        .result(lrOut[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // boolean source bus
  // ----------------------------------------------------------------
  // rules may read rules only through registered bits, so no loop forms
  assign srcBus[`EAS_SRC_FALSE] = 1'b0;
  assign srcBus[`EAS_SRC_TRUE] = 1'b1;
  assign srcBus[`EAS_SRC_STAT +: `EAS_NUM_STAT] = statusBits;
  assign srcBus[`EAS_SRC_CMP +: `EAS_NUM_CMP] = cmpOut;
  assign srcBus[`EAS_SRC_LR +: `EAS_NUM_LR] = lrOut_q;
  assign srcBus[`EAS_SRC_TMR +: `EAS_NUM_TMR] = timerBits;
  assign srcBus[`EAS_SRC_DIN +: `EAS_NUM_DIN] = dinSync_q;
  assign srcBus[`EAS_SRC_EVT] = evtLast_q;
  assign srcBus[`EAS_SRC_RUN] = (state_q == EAS_RUN);

  // registered rule outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lrOut_q <= '0;
    end else begin
      lrOut_q <= lrOut;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // configured pair count clamped to 1..20
  always_comb begin
    if (count_q == '0) begin
      lastIdx = '0;
    end else if (count_q > `EAS_CNT_MAX) begin
      lastIdx = `EAS_CNT_MAX - 5'h01;
    end else begin
      lastIdx = count_q - 5'h01;
    end
  end

  assign curSel = pairCfg_q[idx_q][`EAS_PAIR_EV_LSB +: `EAS_SRC_W];
  assign eventTrue = srcBus[curSel];
  assign idx_d = (idx_q >= lastIdx) ? '0 : idx_q + 5'h01;

  // state and current index
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= EAS_IDLE;
      idx_q <= '0;
    end else begin
      case (state_q)
        EAS_IDLE: begin
          idx_q <= '0;
          if (enable_q) begin
            state_q <= EAS_RUN;
          end
        end
        EAS_RUN: begin
          if (!enable_q) begin
            state_q <= EAS_IDLE;
            idx_q <= '0;
          end else if (scanStrobe && eventTrue) begin
            idx_q <= idx_d;
          end
        end
        default: begin
          state_q <= EAS_IDLE;
          idx_q <= '0;
        end
      endcase
    end
  end

  // action outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      actionFire <= 1'b0;
      actionCode <= '0;
      actionIndex <= '0;
      evtLast_q <= 1'b0;
    end else begin
      actionFire <= 1'b0;
      evtLast_q <= 1'b0;
      if (state_q == EAS_RUN && enable_q && scanStrobe && eventTrue) begin
        actionFire <= 1'b1;
        actionCode <= pairCfg_q[idx_q][`EAS_PAIR_ACT_LSB +: `EAS_ACT_W];
        actionIndex <= idx_q;
        evtLast_q <= 1'b1;
      end
    end
  end

  assign currentIndex = idx_q;

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  assign addrPhase = hsel && htrans[1] && hready;
  assign wOff = addr_q - `EAS_PAIR_BASE;
  assign wPair = wOff[2 +: `EAS_IDX_W];

  // address capture and wait state for reads
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_q <= '0;
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= '0;
      hresp <= 1'b0;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      rdPend_q <= addrPhase && !hwrite;
      if (addrPhase) begin
        addr_q <= {haddr[11:2], 2'b00};
      end
      if (addrPhase && !hwrite) begin
        hreadyout <= 1'b0;
      end else begin
        hreadyout <= 1'b1;
      end
      if (rdPend_q) begin
        hrdata <= rdMux;
      end
    end
  end

  // read decode
  always_comb begin
    rdMux = '0;
    if (addr_q == `EAS_CTRL_OFF) begin
      rdMux[`EAS_CTRL_EN_BIT] = enable_q;
      rdMux[`EAS_CTRL_CNT_LSB +: `EAS_IDX_W] = count_q;
    end else if (addr_q == `EAS_STAT_OFF) begin
      rdMux[`EAS_IDX_W-1:0] = idx_q;
      rdMux[8] = (state_q == EAS_RUN);
      rdMux[9] = eventTrue;
      rdMux[16 +: `EAS_NUM_CMP] = cmpOut;
      rdMux[20 +: `EAS_NUM_LR] = lrOut_q;
    end else if (addr_q >= `EAS_CMP_BASE && addr_q < `EAS_LR_BASE) begin
      rdMux[19:0] = cmpCfg_q[addr_q[3:2]];
    end else if (addr_q >= `EAS_LR_BASE && addr_q < `EAS_LR_BASE + 12'h010) begin
      rdMux[21:0] = lrCfg_q[addr_q[3:2]];
    end else if (addr_q >= `EAS_PAIR_BASE && wPair < `EAS_PAIRS && wOff < 12'h080) begin
      rdMux[13:0] = pairCfg_q[wPair];
    end
  end

  // register writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enable_q <= 1'b0;
      count_q <= `EAS_CNT_RST;
      for (int i = 0; i < `EAS_PAIRS; i++) begin
        pairCfg_q[i] <= '0;
      end
      for (int i = 0; i < `EAS_NUM_CMP; i++) begin
        cmpCfg_q[i] <= '0;
        lrCfg_q[i] <= '0;
      end
    end else if (wrPend_q) begin
      if (addr_q == `EAS_CTRL_OFF) begin
        enable_q <= hwdata[`EAS_CTRL_EN_BIT];
        count_q <= hwdata[`EAS_CTRL_CNT_LSB +: `EAS_IDX_W];
      end else if (addr_q >= `EAS_CMP_BASE && addr_q < `EAS_LR_BASE) begin
        cmpCfg_q[addr_q[3:2]] <= hwdata[19:0];
      end else if (addr_q >= `EAS_LR_BASE && addr_q < `EAS_LR_BASE + 12'h010) begin
        lrCfg_q[addr_q[3:2]] <= hwdata[21:0];
      end else if (addr_q >= `EAS_PAIR_BASE && wPair < `EAS_PAIRS && wOff < 12'h080) begin
        pairCfg_q[wPair] <= {hwdata[`EAS_PAIR_ACT_LSB +: `EAS_ACT_W], 3'h0, hwdata[`EAS_PAIR_EV_LSB +: `EAS_SRC_W]};
      end
    end
  end
endmodule

// ==== tb/eas_chk.sv ====
`timescale 1ns/10ps
`include "eas_params.svh"
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module eas_chk
  import eas_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // sequencer
  input wire logic scanStrobe,
  input wire logic actionFire,
  input wire logic [`EAS_ACT_W-1:0] actionCode,
  input wire logic [`EAS_IDX_W-1:0] actionIndex,
  input wire logic [`EAS_IDX_W-1:0] currentIndex
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // address phase accepted this edge
  wire logic taken = hsel && htrans[1] && hready;
  // a fire always follows a strobe
  chk_fire_after_strobe: assert property (actionFire |-> $past(scanStrobe))
    else $error("fire without strobe");
  // the fired pair is the one that was current
  chk_fire_pair: assert property (actionFire |-> $past(currentIndex) == actionIndex)
    else $error("fired index not current");
  // a fire moves to the next index or wraps to 0
  chk_index_step: assert property (actionFire |-> currentIndex == actionIndex + 1 || currentIndex == 0)
    else $error("bad index step");
  // without a fire the index holds or is forced to 0
  chk_index_hold: assert property (!actionFire |-> $stable(currentIndex) || currentIndex == 0)
    else $error("index moved without fire");
  // action outputs hold between fires
  chk_action_hold: assert property (!actionFire |-> $stable(actionCode) && $stable(actionIndex))
    else $error("action outputs changed");
  // a read has exactly one wait state
  chk_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  // a write has none
  chk_write_zero: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  // response is always okay
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
endmodule
bind event_action_sequencer eas_chk eas_chk_i (
  .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .scanStrobe(scanStrobe), .actionFire(actionFire),
  .actionCode(actionCode), .actionIndex(actionIndex), .currentIndex(currentIndex));

// ==== tb/eas_far_side.sv ====
`timescale 1ns/10ps
`include "eas_params.svh"
// ----------------------------------------------------------------
// drive-side sources and action sink
// ----------------------------------------------------------------
module eas_far_side
  import eas_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // action sink
  input wire logic actionFire,
  // condition sources
  output logic [`EAS_NUM_STAT-1:0] statusBits,
  output logic [`EAS_NUM_TMR-1:0] timerBits,
  output logic [`EAS_NUM_DIN-1:0] digitalPins,
  output logic [`EAS_NUM_CMP*`EAS_VAL_W-1:0] measValues,
  // action log
  output int fireCount
);
  // sources start inactive, bench changes them at edges
  initial begin
    statusBits = '0;
    timerBits = '0;
    digitalPins = '0;
    measValues = '0;
  end
  // count every action the sequencer hands over
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) fireCount <= 0;
    else if (actionFire) fireCount <= fireCount + 1;
  end
endmodule

// ==== tb/event_action_sequencer_tb_top.sv ====
`timescale 1ns/10ps
`include "eas_params.svh"
// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module event_action_sequencer_tb_top
  import eas_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic scanStrobe = 1'b0;
  logic hready, hreadyout, hresp, actionFire;
  logic [31:0] hrdata, rd;
  logic [`EAS_NUM_STAT-1:0] statusBits;
  logic [`EAS_NUM_TMR-1:0] timerBits;
  logic [`EAS_NUM_DIN-1:0] digitalPins;
  logic [`EAS_NUM_CMP*`EAS_VAL_W-1:0] measValues;
  logic [`EAS_ACT_W-1:0] actionCode;
  logic [`EAS_IDX_W-1:0] actionIndex, currentIndex;
  int fireCount;
  int errors = 0;
  int check_count = 0;
  // single slave drives the bus ready
  assign hready = hreadyout;
  always #4 ref_clk = ~ref_clk;
  event_action_sequencer event_action_sequencer_i (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .scanStrobe(scanStrobe), .statusBits(statusBits), .timerBits(timerBits),
    .digitalPins(digitalPins), .measValues(measValues), .actionFire(actionFire),
    .actionCode(actionCode), .actionIndex(actionIndex), .currentIndex(currentIndex));
  eas_far_side eas_far_side_i (
    .ref_clk(ref_clk), .rst(rst), .actionFire(actionFire), .statusBits(statusBits),
    .timerBits(timerBits), .digitalPins(digitalPins), .measValues(measValues), .fireCount(fireCount));
  // verdict and end of run
  task finish_test;
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // wait for ready sampled high, bounded
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (n >= 40) begin
      errors++;
      $display("MISMATCH %0t bus timeout", $time);
      finish_test();
    end
  endtask
  // one single-word transfer
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task bw(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task br(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // one strobe, then judge fire and index
  task strb(input logic f, input logic [4:0] i, input logic [5:0] c, input logic [4:0] nx);
    @(posedge ref_clk);
    scanStrobe <= 1'b1;
    @(posedge ref_clk);
    scanStrobe <= 1'b0;
    #1;
    chk(32'(actionFire), 32'(f));
    if (f) chk({actionIndex, actionCode}, {i, c});
    chk(32'(currentIndex), 32'(nx));
  endtask
  // reset values and an unmapped place
  task t_reset;
    chk(32'(currentIndex), 32'h0);
    br(`EAS_CTRL_OFF, 32'h100);
    br(`EAS_STAT_OFF, 32'h0);
    bw(32'hfc, 32'h5a5a5a5a);
    br(32'hfc, 32'h0);
  endtask
  // twenty pairs, event 0 blocks the rest, full wrap
  task t_walk;
    for (int i = 0; i < 20; i++) bw(32'h40 + 4 * i, {18'h0, 6'(i + 1), 3'h0, (i == 0) ? 5'h2 : 5'h1});
    bw(`EAS_CTRL_OFF, 32'h1401);
    strb(1'b0, 5'h0, 6'h0, 5'h0);
    @(posedge ref_clk) eas_far_side_i.statusBits <= 8'h01;
    for (int i = 0; i < 20; i++) strb(1'b1, 5'(i), 6'(i + 1), 5'((i + 1) % 20));
    // the model counts the last pulse at the edge after it
    @(posedge ref_clk);
    #1;
    chk(32'(fireCount), 32'h14);
  endtask
  // comparator event, one-pair sequence
  task t_cmp;
    bw(`EAS_CTRL_OFF, 32'h101);
    bw(32'h40, 32'h2a0a);
    bw(32'h10, 32'h80064);
    @(posedge ref_clk) eas_far_side_i.measValues <= 64'h64;
    strb(1'b0, 5'h0, 6'h0, 5'h0);
    @(posedge ref_clk) eas_far_side_i.measValues <= 64'h65;
    strb(1'b1, 5'h0, 6'h2a, 5'h0);
  endtask
  // logic rule: timer AND NOT pin
  task t_rule;
    bw(32'h40, 32'h150e);
    bw(32'h20, 32'h1082d2);
    @(posedge ref_clk) eas_far_side_i.timerBits <= 4'h1;
    eas_far_side_i.digitalPins <= 8'h01;
    repeat (4) @(posedge ref_clk);
    strb(1'b0, 5'h0, 6'h0, 5'h0);
    @(posedge ref_clk) eas_far_side_i.digitalPins <= 8'h00;
    repeat (4) @(posedge ref_clk);
    strb(1'b1, 5'h0, 6'h15, 5'h0);
  endtask
  // other comparator and rule operators, disable and restart, reset mid-run
  task t_modes;
    bw(32'h40, 32'h0b0b);
    @(posedge ref_clk) eas_far_side_i.measValues <= 64'h0200_0000;
    bw(32'h14, 32'h50200);
    strb(1'b1, 5'h0, 6'h0b, 5'h0);
    bw(32'h14, 32'h10200);
    strb(1'b0, 5'h0, 6'h0, 5'h0);
    bw(32'h14, 32'hd0200);
    strb(1'b0, 5'h0, 6'h0, 5'h0);
    @(posedge ref_clk) eas_far_side_i.measValues <= 64'h01ff_0000;
    strb(1'b1, 5'h0, 6'h0b, 5'h0);
    bw(32'h14, 32'h10200);
    strb(1'b1, 5'h0, 6'h0b, 5'h0);
    bw(32'h24, 32'h10293);
    bw(32'h40, 32'h0c0f);
    @(posedge ref_clk) eas_far_side_i.timerBits <= 4'h4;
    strb(1'b1, 5'h0, 6'h0c, 5'h0);
    bw(32'h24, 32'h70693);
    strb(1'b0, 5'h0, 6'h0, 5'h0);
    @(posedge ref_clk) eas_far_side_i.timerBits <= 4'h0;
    strb(1'b1, 5'h0, 6'h0c, 5'h0);
    bw(32'h40, 32'h0d01);
    bw(`EAS_CTRL_OFF, 32'h1401);
    strb(1'b1, 5'h0, 6'h0d, 5'h1);
    bw(`EAS_CTRL_OFF, 32'h1400);
    strb(1'b0, 5'h0, 6'h0, 5'h0);
    bw(`EAS_CTRL_OFF, 32'h1401);
    strb(1'b1, 5'h0, 6'h0d, 5'h1);
    @(posedge ref_clk) rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk(32'(currentIndex), 32'h0);
    br(`EAS_CTRL_OFF, 32'h100);
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_walk();
    t_cmp();
    t_rule();
    t_modes();
    finish_test();
  end
endmodule
